// File: verilog/fifo_busy_pkg.sv
// Constants and types shared by the bidirectional FIFO and busy control
`default_nettype none
package fifo_busy_pkg;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 16;
  localparam int DATA_W = 12;
  localparam int TAG_W = 4;
  localparam int XFER_CNT_W = 8;
  localparam int FLAG_W = 12;
  // Flag word bit positions
  localparam int FLAG_OVER_BIT = 8;
  localparam int FLAG_EMPTY_BIT = 9;
  // Channel tags with special meaning
  localparam logic [TAG_W-1:0] TAG_ERR = 4'he;
  localparam logic [TAG_W-1:0] TAG_EMPTY = 4'hf;
  // Conversion clock select codes
  localparam logic [1:0] CKSEL_INT = 2'h0;
  localparam logic [1:0] CKSEL_EXT = 2'h1;
  localparam logic [1:0] CKSEL_SINGLE = 2'h3;
  // Reset values
  localparam logic ALARM_RST = 1'b1;
  typedef enum logic [2:0] {
    MODE_MONITOR = 3'b001,
    MODE_STREAM = 3'b010,
    MODE_MESSAGE = 3'b100
  } mode_e;
endpackage
`default_nettype wire

// File: verilog/fifo_if.sv
// Signals between the FIFO controller and its storage ring
`timescale 1ns/100ps
`default_nettype none
interface fifo_if #(parameter int W = 16, parameter int D = 8);
  logic push;
  logic pop;
  logic clear;
  logic [W-1:0] wrData;
  logic [W-1:0] rdData;
  logic full;
  logic empty;
  logic [$clog2(D):0] count;
  modport ctrl (output push, pop, clear, wrData, input rdData, full, empty, count);
  modport store (input push, pop, clear, wrData, output rdData, full, empty, count);
endinterface
`default_nettype wire

// File: verilog/fifo_ring.sv
// Circular buffer with read and write pointers and an occupancy count
`timescale 1ns/100ps
`default_nettype none
module fifo_ring #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Controller side
  fifo_if.store f
);
  localparam int PW = $clog2(D);
  localparam int CW = PW + 1;

  logic [W-1:0] mem [D];
  logic [PW-1:0] rdPtr_reg;
  logic [PW-1:0] wrPtr_reg;
  logic [CW-1:0] count_reg;
  logic doPop;
  logic doPush;

  // A push into a full ring only lands when a pop frees the slot together
  assign doPop = f.pop && (count_reg != '0);
  assign doPush = f.push && ((count_reg != CW'(D)) || doPop);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdPtr_reg <= '0;
      wrPtr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (f.clear) begin
        rdPtr_reg <= '0;
        wrPtr_reg <= '0;
        count_reg <= '0;
      end else begin
        if (doPop) begin
          rdPtr_reg <= (rdPtr_reg == PW'(D - 1)) ? '0 : rdPtr_reg + 1'b1;
        end
        if (doPush) begin
          wrPtr_reg <= (wrPtr_reg == PW'(D - 1)) ? '0 : wrPtr_reg + 1'b1;
        end
        if (doPush && !doPop) begin
          count_reg <= count_reg + 1'b1;
        end else if (doPop && !doPush) begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && !f.clear && doPush) begin
      mem[wrPtr_reg] <= f.wrData;
    end
  end

  assign f.rdData = mem[rdPtr_reg];
  assign f.count = count_reg;
  assign f.full = (count_reg == CW'(D));
  assign f.empty = (count_reg == '0);
endmodule // fifo_ring
`default_nettype wire

// File: verilog/bidir_fifo_busy_ctrl.sv
// Bidirectional FIFO with monitor, EEPROM streaming and message modes, and busy output
// Functional notes
// [RULE1] One shared FIFO, eight 16-bit words.
// [RULE2] Monitor enabled: push 12-bit result plus channel tag.
// [RULE3] Monitor push when full: drop oldest, set overflow.
// [RULE4] Read colliding overflow push gets error tag.
// [RULE5] Monitor empty read returns empty tag plus flags.
// [RULE6] Entering streaming write clears the FIFO.
// [RULE7] Host stops watchdog oscillator during streaming.
// [RULE8] Streaming pops words to EEPROM, stalls when empty.
// [RULE9] Streaming full sets overflow, ignores host writes.
// [RULE10] Host writes at most one word per 60us.
// [RULE11] Status on alarm: streaming full drives alarm low.
// [RULE12] Status on alarm: message empty drives alarm low.
// [RULE13] Message start clears FIFO, runs until all read.
// [RULE14] Message copy pauses while FIFO full.
// [RULE15] Message underflow read returns empty tag word.
// [RULE16] Host reads at most one word per 50us.
// [RULE17] Empty flag reports empty FIFO for polling.
// [RULE18] Busy during conversions, init, calc, EEPROM, calibration.
// [RULE19] Multi-conversion modes: busy until scan done.
// [RULE20] Continuous mode no busy; clearing it busies.
// [RULE21] Single-conversion mode: busy until conversion done.
// [RULE22] Host waits for busy low between conversions.
// [RULE23] Ring buffer with pointers and occupancy count.
`timescale 1ns/100ps
`default_nettype none
module bidir_fifo_busy_ctrl import fifo_busy_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CNT_W = XFER_CNT_W
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Serial link pins
  input wire logic linkClk,
  input wire logic hostRdReq,
  input wire logic hostWrReq,
  input wire logic [WORD_W-1:0] hostWrData,
  output logic [WORD_W-1:0] hostRdData,
  output logic hostRdValid,
  // Configuration and commands
  input wire logic adcMonitorEnable,
  input wire logic fifoStatusOnAlarm,
  input wire logic continuousConvert,
  input wire logic [1:0] conversionClockSelect,
  input wire logic streamStart,
  input wire logic [CNT_W-1:0] streamCount,
  input wire logic messageStart,
  input wire logic [CNT_W-1:0] messageCount,
  input wire logic flagRead,
  input wire logic [FLAG_W-1:0] flagRegIn,
  // Converter side
  input wire logic convStart,
  input wire logic adcResultValid,
  input wire logic [DATA_W-1:0] adcResult,
  input wire logic [TAG_W-1:0] adcChannel,
  input wire logic adcScanActive,
  input wire logic adcConvDone,
  input wire logic adcScanDone,
  output logic gateSampleValid,
  output logic [DATA_W-1:0] gateSample,
  // Other busy sources
  input wire logic powerUpInit,
  input wire logic gateCalcActive,
  input wire logic pgaCalActive,
  // EEPROM side
  output logic eepromWrValid,
  output logic [WORD_W-1:0] eepromWrData,
  input wire logic eepromWrReady,
  output logic eepromRdReq,
  input wire logic eepromRdValid,
  input wire logic [WORD_W-1:0] eepromRdData,
  // Alarm input and status outputs
  input wire logic alarmIn,
  output logic alarmOut,
  output logic overflowFlag,
  output logic emptyFlag,
  output logic busy
);
  localparam int SYNC_W = WORD_W + 3;

  fifo_if #(.W(WORD_W), .D(DEPTH)) f ();

  fifo_ring #(.W(WORD_W), .D(DEPTH)) ring (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .f(f)
  );

  // ---------------------------------------------------------------
  // Link pin synchroniser
  // ---------------------------------------------------------------
  // Data is captured with the clock pin, so the host must set it up a
  // core clock ahead; the 32 ns half link period leaves ample margin.
  logic [SYNC_W-1:0] pinS1_reg;
  logic [SYNC_W-1:0] pinS2_reg;
  logic linkPrev_reg;
  logic linkRise;
  logic rdEv;
  logic wrEv;
  logic [WORD_W-1:0] wrWord;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinS1_reg <= '0;
      pinS2_reg <= '0;
    end else if (ce) begin
      pinS1_reg <= {linkClk, hostRdReq, hostWrReq, hostWrData};
      pinS2_reg <= pinS1_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      linkPrev_reg <= 1'b0;
    end else if (ce) begin
      linkPrev_reg <= pinS2_reg[SYNC_W-1];
    end
  end

  assign linkRise = pinS2_reg[SYNC_W-1] && !linkPrev_reg;
  assign rdEv = linkRise && pinS2_reg[SYNC_W-2];
  assign wrEv = linkRise && pinS2_reg[SYNC_W-3];
  assign wrWord = pinS2_reg[WORD_W-1:0];

  // ---------------------------------------------------------------
  // FIFO traffic
  // ---------------------------------------------------------------
  mode_e mode_reg;
  logic isMon;
  logic isStr;
  logic isMsg;
  logic monPush;
  logic strPush;
  logic msgPush;
  logic hostPop;
  logic collide;
  logic dropOld;
  logic wrPop;
  logic rdPend_reg;
  logic [CNT_W-1:0] wrRemain_reg;
  logic [CNT_W-1:0] cpRemain_reg;
  logic [CNT_W-1:0] rdRemain_reg;
  logic [FLAG_W-1:0] flagWord;

  assign isMon = (mode_reg == MODE_MONITOR);
  assign isStr = (mode_reg == MODE_STREAM);
  assign isMsg = (mode_reg == MODE_MESSAGE);

  assign monPush = isMon && adcMonitorEnable && adcResultValid; // [RULE2]
  assign hostPop = rdEv && (isMon || isMsg) && !f.empty;
  assign collide = monPush && f.full && rdEv; // [RULE4]
  // Full ring: the oldest word makes room unless a read takes it already
  assign dropOld = monPush && f.full && !hostPop; // [RULE3]
  // Full ring in streaming: the host word is simply not pushed
  assign strPush = isStr && wrEv && !f.full; // [RULE9]
  assign wrPop = isStr && !eepromWrValid && !f.empty && (wrRemain_reg != '0); // [RULE8]
  assign msgPush = isMsg && rdPend_reg && eepromRdValid;
  assign eepromRdReq = isMsg && (cpRemain_reg != '0) && !f.full && !rdPend_reg; // [RULE14]

  assign f.push = monPush || strPush || msgPush;
  assign f.pop = hostPop || dropOld || wrPop;
  assign f.clear = streamStart || messageStart; // [RULE6] [RULE13]
  assign f.wrData = isMon ? {adcChannel, adcResult} : (isStr ? wrWord : eepromRdData);
  assign emptyFlag = f.empty; // [RULE17]

  always_comb begin
    flagWord = flagRegIn;
    flagWord[FLAG_OVER_BIT] = overflowFlag;
    flagWord[FLAG_EMPTY_BIT] = f.empty;
  end

  // ---------------------------------------------------------------
  // Mode sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= MODE_MONITOR;
    end else if (ce) begin
      if (streamStart) begin
        mode_reg <= MODE_STREAM;
      end else if (messageStart) begin
        mode_reg <= MODE_MESSAGE; // [RULE13]
      end else begin
        case (mode_reg)
          MODE_STREAM: begin
            if ((wrRemain_reg == '0) && !eepromWrValid) begin
              mode_reg <= MODE_MONITOR;
            end
          end
          MODE_MESSAGE: begin
            if ((cpRemain_reg == '0) && (rdRemain_reg == '0)) begin
              mode_reg <= MODE_MONITOR; // [RULE13]
            end
          end
          default: begin
            mode_reg <= MODE_MONITOR;
          end
        endcase
      end
    end
  end

  // Streaming write to the EEPROM, one word in flight at a time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrRemain_reg <= '0;
      eepromWrValid <= 1'b0;
      eepromWrData <= '0;
    end else if (ce) begin
      if (streamStart || messageStart) begin
        wrRemain_reg <= streamStart ? streamCount : '0;
        eepromWrValid <= 1'b0;
      end else if (wrPop) begin
        eepromWrValid <= 1'b1; // [RULE8]
        eepromWrData <= f.rdData;
      end else if (eepromWrValid && eepromWrReady) begin
        eepromWrValid <= 1'b0;
        wrRemain_reg <= wrRemain_reg - 1'b1;
      end
    end
  end

  // Message copy and read-out counters
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpRemain_reg <= '0;
      rdRemain_reg <= '0;
      rdPend_reg <= 1'b0;
    end else if (ce) begin
      if (streamStart || messageStart) begin
        cpRemain_reg <= messageStart ? messageCount : '0;
        rdRemain_reg <= messageStart ? messageCount : '0;
        rdPend_reg <= 1'b0;
      end else begin
        if (eepromRdReq) begin
          rdPend_reg <= 1'b1;
        end else if (msgPush) begin
          rdPend_reg <= 1'b0;
          cpRemain_reg <= cpRemain_reg - 1'b1;
        end
        if (hostPop && isMsg && (rdRemain_reg != '0)) begin
          rdRemain_reg <= rdRemain_reg - 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Host read answer
  // ---------------------------------------------------------------
  // An empty read carries no payload, so it returns the flag word instead;
  // in message mode this cannot be told from EEPROM data.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hostRdValid <= 1'b0;
      hostRdData <= '0;
    end else if (ce) begin
      hostRdValid <= rdEv && (isMon || isMsg);
      if (rdEv && (isMon || isMsg)) begin
        if (f.empty) begin
          hostRdData <= {TAG_EMPTY, flagWord}; // [RULE5] [RULE15]
        end else if (collide) begin
          hostRdData <= {TAG_ERR, f.rdData[DATA_W-1:0]}; // [RULE4]
        end else begin
          hostRdData <= f.rdData;
        end
      end
    end
  end

  // The gate calculation takes every sample straight from the converter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gateSampleValid <= 1'b0;
      gateSample <= '0;
    end else if (ce) begin
      gateSampleValid <= adcResultValid; // [RULE4]
      if (adcResultValid) begin
        gateSample <= adcResult;
      end
    end
  end

  // ---------------------------------------------------------------
  // Overflow flag and alarm pin
  // ---------------------------------------------------------------
  // Set wins over a same-cycle flag read so no overflow is lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflowFlag <= 1'b0;
    end else if (ce) begin
      if ((monPush && f.full) || (isStr && f.full)) begin
        overflowFlag <= 1'b1; // [RULE3] [RULE9]
      end else if (flagRead) begin
        overflowFlag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarmOut <= ALARM_RST;
    end else if (ce) begin
      if (fifoStatusOnAlarm && isStr) begin
        alarmOut <= !f.full; // [RULE11]
      end else if (fifoStatusOnAlarm && isMsg) begin
        alarmOut <= !f.empty; // [RULE12]
      end else begin
        alarmOut <= alarmIn;
      end
    end
  end

  // ---------------------------------------------------------------
  // Busy output
  // ---------------------------------------------------------------
  logic convBusy_reg;
  logic contPrev_reg;
  logic convSet;
  logic convClr;

  // Dropping continuous mode mid-scan must hold busy until the scan halts
  assign convSet = (convStart && !continuousConvert) ||
                   (contPrev_reg && !continuousConvert && adcScanActive); // [RULE20]
  assign convClr = (conversionClockSelect == CKSEL_SINGLE) ? adcConvDone : adcScanDone;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      contPrev_reg <= 1'b0;
    end else if (ce) begin
      contPrev_reg <= continuousConvert;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      convBusy_reg <= 1'b0;
    end else if (ce) begin
      if (convSet) begin
        convBusy_reg <= 1'b1;
      end else if (convClr) begin
        convBusy_reg <= 1'b0; // [RULE19] [RULE21]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (ce) begin
      busy <= convBusy_reg || powerUpInit || gateCalcActive || pgaCalActive ||
              !isMon; // [RULE18]
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_ring_depth: assert property (f.count <= DEPTH) // [RULE1] [RULE23]
    else $error("FIFO occupancy above depth");
  a_monitor_push: assert property (ce && monPush && !f.full && !f.pop |=>
    f.count == $past(f.count) + 1'b1) // [RULE2]
    else $error("Monitor result not stored");
  a_overflow_set: assert property (ce && monPush && f.full |=>
    overflowFlag && f.full) // [RULE3]
    else $error("Overflow not flagged or ring not kept full");
  a_collide_tag: assert property (ce && collide |=>
    hostRdValid && hostRdData[WORD_W-1:DATA_W] == TAG_ERR) // [RULE4]
    else $error("Collision read lacks error tag");
  a_empty_tag: assert property (ce && rdEv && f.empty && (isMon || isMsg) |=>
    hostRdValid && hostRdData[WORD_W-1:DATA_W] == TAG_EMPTY) // [RULE5]
    else $error("Empty read lacks empty tag");
  a_stream_clear: assert property (ce && streamStart |=> f.empty && isStr) // [RULE6]
    else $error("Streaming entry did not clear FIFO");
  a_write_ignored: assert property (ce && isStr && wrEv && f.full && !f.pop |=>
    f.count == $past(f.count)) // [RULE9]
    else $error("Write into full FIFO accepted");
  a_alarm_full: assert property (ce && fifoStatusOnAlarm && isStr && f.full &&
    !streamStart && !messageStart |=> !alarmOut) // [RULE11]
    else $error("Alarm not low on full FIFO");
  a_alarm_empty: assert property (ce && fifoStatusOnAlarm && isMsg && f.empty &&
    !streamStart && !messageStart |=> !alarmOut) // [RULE12]
    else $error("Alarm not low on empty FIFO");
  a_copy_pause: assert property (eepromRdReq |-> !f.full && isMsg) // [RULE14]
    else $error("EEPROM copy requested while full");
  a_busy_mode: assert property (ce && !isMon |=> busy) // [RULE18]
    else $error("Busy low during EEPROM mode");
  a_single_done: assert property (ce && !convSet && convBusy_reg &&
    conversionClockSelect == CKSEL_SINGLE && adcConvDone |=> ##1 !busy || powerUpInit ||
    gateCalcActive || pgaCalActive || !isMon || convBusy_reg) // [RULE21]
    else $error("Busy held after single conversion");
  a_cont_quiet: assert property (ce && convStart && continuousConvert &&
    !convBusy_reg && !contPrev_reg |=> !convBusy_reg) // [RULE20]
    else $error("Continuous conversion raised busy");

  c_overflow: cover property (ce && dropOld);
  c_collide: cover property (ce && collide);
  c_stream_done: cover property (isStr ##1 isMon);
  c_message_done: cover property (isMsg ##1 isMon);
endmodule // bidir_fifo_busy_ctrl
`default_nettype wire

// File: tb/link_host.sv
// Host-side link model: one read or write per pulse of the link clock
`timescale 1ns/100ps
`default_nettype none
module link_host import fifo_busy_pkg::*; #(
  parameter int GAP_NS = 0
) (
  // Link pins
  output logic linkClk,
  output logic hostRdReq,
  output logic hostWrReq,
  output logic [WORD_W-1:0] hostWrData
);
  initial begin
    linkClk = 1'b0;
    hostRdReq = 1'b0;
    hostWrReq = 1'b0;
    hostWrData = '0;
  end
  // Request and data lead the rising edge by half a 64 ns period
  task automatic frame(input logic rd, input logic wr, input logic [WORD_W-1:0] d);
    hostRdReq = rd;
    hostWrReq = wr;
    hostWrData = d;
    #32 linkClk = 1'b1;
    #32 linkClk = 1'b0;
    hostRdReq = 1'b0;
    hostWrReq = 1'b0;
    // Released data shows the inverse so a stale word never looks valid
    hostWrData = ~d;
    // Open-loop pacing; the bench leaves GAP_NS at 0 to provoke full and empty
    #(GAP_NS + 1);
  endtask
endmodule // link_host
`default_nettype wire

// File: tb/bidir_fifo_busy_ctrl_tb_top.sv
// Self-checking bench for the bidirectional FIFO and busy control
`timescale 1ns/100ps
`default_nettype none
module bidir_fifo_busy_ctrl_tb_top import fifo_busy_pkg::*; ;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic linkClk, hostRdReq, hostWrReq, hostRdValid, gateSampleValid;
  logic [WORD_W-1:0] hostWrData, hostRdData, eepromWrData, w;
  logic [WORD_W-1:0] eepromRdData = '0;
  logic adcMonitorEnable, fifoStatusOnAlarm, continuousConvert, streamStart, messageStart;
  logic flagRead, convStart, adcScanActive, adcConvDone, adcScanDone, eeOn;
  logic powerUpInit, gateCalcActive, pgaCalActive, eepromWrValid, eepromWrReady;
  logic eepromRdReq, alarmIn, alarmOut, overflowFlag, emptyFlag, busy;
  logic adcResultValid = 1'b0;
  logic eepromRdValid = 1'b0;
  logic lastV = 1'b0;
  logic [1:0] conversionClockSelect;
  logic [1:0] sels[3] = '{CKSEL_INT, CKSEL_EXT, CKSEL_SINGLE};
  logic [7:0] streamCount, messageCount;
  logic [FLAG_W-1:0] flagRegIn;
  logic [DATA_W-1:0] adcResult, gateSample, lastRes;
  logic [TAG_W-1:0] adcChannel;
  logic [WORD_W-1:0] rdQ[$], ewQ[$], wrExp[$], recent[$], msgExp[$];
  int seed = 78256;
  int mismatches = 0;
  int numChecks = 0;
  int floodN = 0;
  int pendReq = 0;
  int reqs = 0;

  bidir_fifo_busy_ctrl #(.DEPTH(8), .CNT_W(8)) uut (.*);
  link_host host (.*);

  always #2 core_clk = ~core_clk;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic link_rd(output logic [WORD_W-1:0] d);
    @(negedge core_clk);
    host.frame(1'b1, 1'b0, WORD_W'($random(seed)));
    tick(6);
    d = (rdQ.size() > 0) ? rdQ.pop_front() : 'x;
  endtask
  task automatic link_wr(input logic [WORD_W-1:0] d);
    @(negedge core_clk);
    host.frame(1'b0, 1'b1, d);
    tick(2);
  endtask
  function automatic logic [WORD_W-1:0] emptyWord(input logic ovf);
    logic [FLAG_W-1:0] f;
    f = flagRegIn;
    f[FLAG_OVER_BIT] = ovf;
    f[FLAG_EMPTY_BIT] = 1'b1;
    return {TAG_EMPTY, f};
  endfunction

  // --------------------------------------------------------------------
  // Converter, EEPROM and capture models
  // --------------------------------------------------------------------
  // Only the newest eight pushes can still be in the ring
  always @(negedge core_clk) begin
    if (lastV) begin
      check(WORD_W'(gateSampleValid), 16'h0001);
      check(WORD_W'(gateSample), WORD_W'(lastRes));
    end
    lastV = floodN > 0;
    adcResultValid = lastV;
    if (lastV) begin
      adcChannel = TAG_W'({$random(seed)} % 14);
      adcResult = DATA_W'($random(seed));
      lastRes = adcResult;
      recent.push_back({adcChannel, adcResult});
      if (recent.size() > 8) recent.pop_front();
      floodN--;
    end
  end
  always @(posedge core_clk) begin
    if (hostRdValid === 1'b1) rdQ.push_back(hostRdData);
    if (eepromWrValid === 1'b1 && eepromWrReady === 1'b1) ewQ.push_back(eepromWrData);
    if (eepromRdReq === 1'b1) begin
      reqs++;
      pendReq++;
    end
  end
  // Answers held back while eeOn is low, so the ring can be left empty
  always @(negedge core_clk) begin
    eepromRdValid = eeOn && pendReq > 0 && !eepromRdValid;
    if (eepromRdValid) begin
      eepromRdData = WORD_W'($random(seed));
      msgExp.push_back(eepromRdData);
      pendReq--;
    end
  end

  // Roughly twenty times the expected run
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    {adcMonitorEnable, fifoStatusOnAlarm, continuousConvert, streamStart, messageStart,
     flagRead, convStart, adcScanActive, adcConvDone, adcScanDone, powerUpInit,
     gateCalcActive, pgaCalActive, eepromWrReady, eeOn} = '0;
    alarmIn = 1'b1;
    conversionClockSelect = CKSEL_INT;
    streamCount = 8'h0a;
    messageCount = 8'h0a;
    flagRegIn = FLAG_W'($random(seed));
    tick(2);
    rst = 1'b0;
    tick(1);
    check(WORD_W'({alarmOut, overflowFlag, emptyFlag, busy}), 16'h000a);
    alarmIn = 1'b0;
    tick(2);
    check(WORD_W'(alarmOut), 16'h0000);
    alarmIn = 1'b1;
    adcMonitorEnable = 1'b1;
    floodN = 5;
    wait (floodN == 0);
    tick(2);
    check(WORD_W'(emptyFlag), 16'h0000);
    repeat (5) begin
      link_rd(w);
      check(w, recent.pop_front());
    end
    link_rd(w);
    check(w, emptyWord(1'b0));
    floodN = 11;
    wait (floodN == 0);
    tick(2);
    check(WORD_W'(overflowFlag), 16'h0001);
    floodN = 40;
    link_rd(w);
    check(WORD_W'(w[15:12]), WORD_W'(TAG_ERR));
    wait (floodN == 0);
    tick(2);
    repeat (8) begin
      link_rd(w);
      check(w, recent.pop_front());
    end
    link_rd(w);
    check(w, emptyWord(1'b1));
    pulse(flagRead);
    tick(1);
    check(WORD_W'(overflowFlag), 16'h0000);
    floodN = 3;
    wait (floodN == 0);
    adcMonitorEnable = 1'b0;
    fifoStatusOnAlarm = 1'b1;
    // Host has stopped the watchdog oscillator for the streaming run
    pulse(streamStart);
    tick(2);
    check(WORD_W'({emptyFlag, busy}), 16'h0003);
    repeat (10) begin
      wrExp.push_back(WORD_W'($random(seed)));
      link_wr(wrExp[$]);
    end
    // One word waits in the EEPROM write register, eight fill the ring,
    // so the tenth meets a full ring and is dropped
    void'(wrExp.pop_back());
    check(WORD_W'({alarmOut, overflowFlag}), 16'h0001);
    eepromWrReady = 1'b1;
    tick(60);
    check(WORD_W'(ewQ.size()), 16'h0009);
    check(WORD_W'({alarmOut, busy}), 16'h0003);
    repeat (2) begin
      wrExp.push_back(WORD_W'($random(seed)));
      link_wr(wrExp[$]);
    end
    tick(20);
    check(WORD_W'({ewQ.size(), busy}), 16'h0014);
    while (ewQ.size() > 0) check(ewQ.pop_front(), wrExp.pop_front());
    pulse(flagRead);
    eepromWrReady = 1'b0;
    pulse(messageStart);
    tick(3);
    check(WORD_W'({alarmOut, emptyFlag, busy}), 16'h0003);
    link_rd(w);
    check(w, emptyWord(1'b0));
    eeOn = 1'b1;
    tick(60);
    check(WORD_W'(reqs), 16'h0008);
    check(WORD_W'({alarmOut, emptyFlag}), 16'h0002);
    repeat (10) begin
      link_rd(w);
      check(w, msgExp.pop_front());
    end
    tick(4);
    check(WORD_W'({reqs, busy}), 16'h0014);
    foreach (sels[i]) begin
      conversionClockSelect = sels[i];
      pulse(convStart);
      tick(2);
      check(WORD_W'(busy), 16'h0001);
      pulse(adcConvDone);
      tick(2);
      check(WORD_W'(busy), WORD_W'(sels[i] != CKSEL_SINGLE));
      pulse(adcScanDone);
      tick(2);
      check(WORD_W'(busy), 16'h0000);
    end
    conversionClockSelect = CKSEL_INT;
    continuousConvert = 1'b1;
    pulse(convStart);
    tick(2);
    check(WORD_W'(busy), 16'h0000);
    adcScanActive = 1'b1;
    continuousConvert = 1'b0;
    tick(3);
    check(WORD_W'(busy), 16'h0001);
    pulse(adcScanDone);
    adcScanActive = 1'b0;
    tick(2);
    check(WORD_W'(busy), 16'h0000);
    for (int k = 0; k < 3; k++) begin
      {powerUpInit, gateCalcActive, pgaCalActive} = 3'b100 >> k;
      tick(2);
      check(WORD_W'(busy), 16'h0001);
    end
    {powerUpInit, gateCalcActive, pgaCalActive} = 3'b000;
    tick(2);
    check(WORD_W'(busy), 16'h0000);
    // A low clock enable must freeze the busy register
    ce = 1'b0;
    powerUpInit = 1'b1;
    tick(3);
    check(WORD_W'(busy), 16'h0000);
    ce = 1'b1;
    tick(3);
    check(WORD_W'(busy), 16'h0001);
    powerUpInit = 1'b0;
    tick(2);
    report_and_stop();
  end
endmodule // bidir_fifo_busy_ctrl_tb_top
`default_nettype wire
